/* dv/mcb_capability_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module mcb_capability_monitor #(
    parameter [7:0]  CAP_LIST_START = 8'h80,
    parameter [31:0] EXT_CAP_HEADER = 32'h0000_0000
) (
    // clock, reset and bus
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // message write
    input wire logic        msg_valid,
    input wire logic [63:0] msg_addr,
    input wire logic        msg_wide,
    input wire logic [15:0] msg_data,
    input wire logic        msg_ready
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // read taken at this edge; its data stands two edges on
    wire logic rd = hsel && hready && htrans[1] && !hwrite;
    AST_CTRL_FIXED: assert property (rd && haddr[11:0] == 12'h080 |-> ##2
        hreadyout && hrdata[31:23] == 9'h003 && hrdata[19:17] == 3'h3 && hrdata[15:0] == 16'hA005)
        else $error("ctrl bits");
    // the slave never signals an error
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("resp not okay");
    AST_ADDR_READ: assert property (rd && haddr[11:0] == 12'h084 |-> ##2
        hreadyout && hrdata[1:0] == 2'h0) else $error("addr low bits");
    AST_LIST_PTR: assert property (rd && haddr[11:0] == 12'h034 |-> ##2
        hreadyout && hrdata == {24'h00_0000, CAP_LIST_START}) else $error("list pointer");
    AST_EXT_CAP: assert property (rd && haddr[11:0] == 12'h100 |-> ##2
        hreadyout && hrdata == EXT_CAP_HEADER) else $error("ext header");
    AST_MSG_ALIGN: assert property (msg_valid |-> msg_addr[1:0] == 2'h0)
        else $error("msg addr align");
    AST_MSG_WIDE: assert property (msg_valid |-> msg_wide == (msg_addr[63:32] != 32'h0))
        else $error("msg wide");
    // a stalled host must see the same write until it takes it
    AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr)
        && $stable(msg_data) && $stable(msg_wide)) else $error("msg hold");
    AST_MSG_DROP: assert property (msg_valid && msg_ready |=> !msg_valid)
        else $error("msg drop");
endmodule
bind mcb_capability mcb_capability_monitor #(.CAP_LIST_START(CAP_LIST_START),
    .EXT_CAP_HEADER(EXT_CAP_HEADER)) i_mon (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .msg_valid, .msg_addr, .msg_wide,
    .msg_data, .msg_ready);
`default_nettype wire

/* dv/mcb_upstream_host.sv */
`timescale 1ns/1ps
`default_nettype none
module mcb_upstream_host (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // cycles to stall before accepting
    input  wire logic [3:0]  stall,
    // message write from the device
    input  wire logic        msg_valid,
    input  wire logic [63:0] msg_addr,
    input  wire logic        msg_wide,
    input  wire logic [15:0] msg_data,
    output var  logic        msg_ready,
    // count and copy of the last write taken
    output var  logic [7:0]  got_count,
    output var  logic [80:0] got
);
    logic [3:0] waited;
    // ready only after the stall, so the device must hold its write
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            msg_ready <= 1'h0;
            waited    <= 4'h0;
            got_count <= 8'h0;
            got       <= 81'h0;
        end else begin
            msg_ready <= msg_valid && !msg_ready && waited >= stall;
            waited    <= (msg_valid && !msg_ready) ? waited + 4'h1 : 4'h0;
            if (msg_valid && msg_ready) begin
                got_count <= got_count + 8'h1;
                got       <= {msg_wide, msg_addr, msg_data};
            end
        end
    end
endmodule
`default_nettype wire

/* dv/tb_mcb_capability.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_mcb_capability;
    localparam [7:0]  LIST = 8'h80;
    localparam [31:0] EXT  = 32'h1234_0001;
    logic        clock = 1'h0, sys_rst = 1'h1, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  source_pin = 8'h0, n;
    logic [3:0]  stall = 4'h0;
    wire         hreadyout, hresp, irq, msg_valid, msg_wide, msg_ready;
    wire  [31:0] hrdata;
    wire  [63:0] msg_addr;
    wire  [15:0] msg_data;
    wire  [7:0]  got_count;
    wire  [80:0] got;
    int          err_count = 0, checks_done = 0, cycles = 0;

    always #12.5 clock = ~clock;

    mcb_capability #(.CAP_LIST_START(LIST), .EXT_CAP_HEADER(EXT)) i_dut (.clock, .sys_rst,
        .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .source_pin, .irq, .msg_valid, .msg_addr, .msg_wide,
        .msg_data, .msg_ready);
    mcb_upstream_host i_host (.clock, .sys_rst, .stall, .msg_valid, .msg_addr, .msg_wide,
        .msg_data, .msg_ready, .got_count, .got);

    task automatic chk(input string s, input logic [80:0] seen, input logic [80:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // single word transfer; waits on hready, never on a fixed latency
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clock);
        while (hreadyout !== 1'h1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'h1) @(posedge clock);
        rdat = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk("register", 81'(rdat), 81'(e));
    endtask
    // pin held long enough for the input synchroniser
    task automatic pulse(input int v);
        source_pin[v] <= 1'h1;
        repeat (4) @(posedge clock);
        source_pin[v] <= 1'h0;
        repeat (4) @(posedge clock);
    endtask
    task automatic wait_msg();
        for (int k = 0; k < 300 && got_count === n; k++) @(posedge clock);
        chk("msg count", 81'(got_count), 81'(n + 8'h1));
    endtask
    task automatic t_reset();
        logic [11:0] a[6] = '{12'h034, 12'h080, 12'h084, 12'h088, 12'h100, 12'h0F0};
        logic [31:0] e[6] = '{{24'h0, LIST}, 32'h0186_A005, 32'h0, 32'h0, EXT, 32'h0};
        foreach (a[i]) rd(a[i], e[i]);
        bus(1'h1, 12'h080, 32'hFFBF_FFFF);
        rd(12'h080, 32'h01B7_A005);
        bus(1'h1, 12'h084, 32'hFFFF_FFFF);
        rd(12'h084, 32'hFFFF_FFFC);
        bus(1'h1, 12'h080, 32'h0);
        $display("test registers done");
    endtask
    task automatic t_msg();
        logic [2:0]  al[4] = '{3'h3, 3'h2, 3'h1, 3'h0};
        logic [31:0] hi[4] = '{32'h0, 32'h0000_0001, 32'h0, 32'hFFFF_0000};
        int          v[4]  = '{5, 6, 3, 7};
        logic [15:0] d[4]  = '{16'hABC5, 16'hABC2, 16'hABC1, 16'hABC0};
        bus(1'h1, 12'h08C, 32'hFFFF_ABC0);
        rd(12'h08C, 32'h0000_ABC0);
        bus(1'h1, 12'h084, 32'h1234_5679);
        foreach (al[i]) begin
            stall <= 4'(3 * i);
            bus(1'h1, 12'h080, {9'h0, al[i], 4'h1, 16'h0});
            bus(1'h1, 12'h088, hi[i]);
            n = got_count;
            pulse(v[i]);
            wait_msg();
            chk("message", got, {hi[i] != 32'h0, hi[i], 32'h1234_5678, d[i]});
        end
        rd(12'h088, 32'hFFFF_0000);
        $display("test messages done");
    endtask
    task automatic t_gate();
        n = got_count;
        bus(1'h1, 12'h080, {9'h0, 3'h3, 4'h0, 16'h0});
        pulse(2);
        repeat (20) @(posedge clock);
        chk("held off", 81'({msg_valid, got_count}), 81'({1'h0, n}));
        bus(1'h1, 12'h080, {9'h0, 3'h3, 4'h1, 16'h0});
        wait_msg();
        chk("late data", 81'(got[15:0]), 81'hABC2);
        $display("test enable done");
    endtask
    task automatic t_irq();
        bus(1'h1, 12'h0C0, 32'h0000_00FF);
        bus(1'h1, 12'h0C4, 32'h0000_0002);
        pulse(0);
        chk("irq masked", 81'(irq), 81'h0);
        pulse(1);
        chk("irq raised", 81'(irq), 81'h1);
        rd(12'h0C0, 32'h0000_0003);
        bus(1'h1, 12'h0C0, 32'h0000_0002);
        repeat (2) @(posedge clock);
        chk("irq cleared", 81'(irq), 81'h0);
        rd(12'h0C0, 32'h0000_0001);
        $display("test interrupt done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        t_reset();
        t_msg();
        t_gate();
        t_irq();
        results();
    end
endmodule
`default_nettype wire

/* hdl/mcb_capability.v */
// How it works
// - the first extended capability header reads at its own fixed offset whatever any pointer holds.
// - a read-only capabilities pointer at a fixed offset names the first capability in the list.
// - bit 24 of the control word reads one, though the mask at 0C4 gates only irq per source, never the message writes.
// - bit 23 of the control word reads one to say a wide address can be sent.
// - bits 19:17 read three, a fixed request for eight vectors.
// - bit 16 is a writable enable, zero at reset, set to one to let messages out.
// - bits 15:8 read a fixed next pointer of A0.
// - bits 7:0 read the fixed identifier 05.
// - when enabled, address bits 31:2 form the word-aligned target of the message write.
// - address bits 1:0 go out as zero and read as zero.
// - a nonzero high address word makes the message a wide one with those upper bits.
// - a zero high address word makes the message a plain 32-bit one.
// - each interrupt edge on a source not already pending sends the programmed 16-bit payload as a posted write to the address.
// - only as many low payload bits as the allocation allows carry the vector number.
`timescale 1ns/1ps
`default_nettype none
`include "mcb_defs.vh"

module mcb_capability #(
    parameter [7:0]  CAP_LIST_START  = 8'h80,
    parameter [31:0] EXT_CAP_HEADER  = 32'h0000_0000
) (
    // clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    // interrupt sources, asynchronous pins
    input  wire [7:0]  source_pin,
    // local interrupt line
    output reg         irq,
    // upstream posted message write
    output wire        msg_valid,
    output wire [63:0] msg_addr,
    output wire        msg_wide,
    output wire [15:0] msg_data,
    input  wire        msg_ready
);

    // software state
    reg        enable;
    reg [2:0]  alloc;
    reg [29:0] addr_low;
    reg [31:0] addr_high;
    reg [15:0] payload;
    reg [7:0]  status;
    reg [7:0]  mask;
    reg [7:0]  pending;

    // bus phase tracking
    reg        wr_pend;
    reg        rd_pend;
    reg [11:0] ph_addr;

    // source synchronisers and edge detect
    reg [7:0]  src_meta;
    reg [7:0]  src_sync;
    reg [7:0]  src_last;

    wire [7:0] grant;
    wire [7:0] rise = src_sync & ~src_last;
    wire       take = hsel && hready && (htrans == `MCB_HTRANS_NONSEQ ||
                                         htrans == `MCB_HTRANS_SEQ);

    // control word assembled from fixed and writable fields
    function [31:0] mcb_control_word;
        input       en;
        input [2:0] al;
        begin
            mcb_control_word = 32'h0000_0000;
            mcb_control_word[`MCB_MASKING_BIT] = `MCB_MASKING_VALUE;
            mcb_control_word[`MCB_WIDE_BIT] = `MCB_WIDE_VALUE;
            mcb_control_word[`MCB_ALLOC_HI:`MCB_ALLOC_LO] = al;
            mcb_control_word[`MCB_REQ_HI:`MCB_REQ_LO] = `MCB_REQ_VALUE;
            mcb_control_word[`MCB_ENABLE_BIT] = en;
            mcb_control_word[`MCB_NEXT_HI:`MCB_NEXT_LO] = `MCB_NEXT_VALUE;
            mcb_control_word[`MCB_CAPID_HI:`MCB_CAPID_LO] = `MCB_CAPID_VALUE;
        end
    endfunction

    // register read decode, unmapped offsets read zero
    function [31:0] mcb_read;
        input [11:0] a;
        begin
            case (a)
                `MCB_OFS_CAP_POINTER: mcb_read = {24'h00_0000, CAP_LIST_START};
                `MCB_OFS_CONTROL:     mcb_read = mcb_control_word(enable, alloc);
                `MCB_OFS_ADDR_LOW:    mcb_read = {addr_low, 2'b00};
                `MCB_OFS_ADDR_HIGH:   mcb_read = addr_high;
                `MCB_OFS_PAYLOAD:     mcb_read = {16'h0000, payload};
                `MCB_OFS_IRQ_STATUS:  mcb_read = {24'h00_0000, status};
                `MCB_OFS_IRQ_MASK:    mcb_read = {24'h00_0000, mask};
                `MCB_OFS_EXT_CAP:     mcb_read = EXT_CAP_HEADER;
                default:              mcb_read = 32'h0000_0000;
            endcase
        end
    endfunction

    // two flops before anything looks at the pins
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            src_meta <= 8'h00;
            src_sync <= 8'h00;
            src_last <= 8'h00;
        end else begin
            src_meta <= source_pin;
            src_sync <= src_meta;
            src_last <= src_sync;
        end
    end

    // ahb phases: writes finish with no wait, reads take one wait so
    // a read right behind a write sees the freshly written value
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            ph_addr   <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= `MCB_HRESP_OKAY;
            hrdata    <= 32'h0000_0000;
        end else begin
            hresp <= `MCB_HRESP_OKAY;
            if (rd_pend) begin
                hrdata    <= mcb_read(ph_addr);
                hreadyout <= 1'b1;
                rd_pend   <= 1'b0;
            end else if (take) begin
                ph_addr   <= {haddr[11:2], 2'b00};
                wr_pend   <= hwrite;
                rd_pend   <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                wr_pend <= 1'b0;
            end
            if (take && hwrite && !rd_pend)
                wr_pend <= 1'b1;
            else if (!take || rd_pend)
                wr_pend <= 1'b0;
        end
    end

    // register writes; event set wins over a write-one clear
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            enable    <= `MCB_ENABLE_RESET;
            alloc     <= `MCB_ALLOC_RESET;
            addr_low  <= 30'h0000_0000;
            addr_high <= 32'h0000_0000;
            payload   <= 16'h0000;
            status    <= 8'h00;
            mask      <= 8'h00;
        end else begin
            if (wr_pend) begin
                case (ph_addr)
                    `MCB_OFS_CONTROL: begin
                        enable <= hwdata[`MCB_ENABLE_BIT];
                        alloc  <= hwdata[`MCB_ALLOC_HI:`MCB_ALLOC_LO];
                    end
                    `MCB_OFS_ADDR_LOW:   addr_low  <= hwdata[31:2];
                    `MCB_OFS_ADDR_HIGH:  addr_high <= hwdata;
                    `MCB_OFS_PAYLOAD:    payload   <= hwdata[15:0];
                    `MCB_OFS_IRQ_MASK:   mask      <= hwdata[7:0];
                    default: ;
                endcase
            end
            if (wr_pend && ph_addr == `MCB_OFS_IRQ_STATUS)
                status <= (status & ~hwdata[7:0]) | rise;
            else
                status <= status | rise;
        end
    end

    // message requests wait here until the writer grants them
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            pending <= 8'h00;
        else
            pending <= (pending & ~grant) | rise;
    end

    // level interrupt while any unmasked status bit stands
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(status & mask);
    end

    // the posted-write engine; its outputs are flops
    mcb_msg_writer u_writer (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .pending   (pending),
        .enable    (enable),
        .alloc     (alloc),
        .addr_low  (addr_low),
        .addr_high (addr_high),
        .payload   (payload),
        .grant     (grant),
        .msg_valid (msg_valid),
        .msg_addr  (msg_addr),
        .msg_wide  (msg_wide),
        .msg_data  (msg_data),
        .msg_ready (msg_ready)
    );

endmodule

`default_nettype wire

/* hdl/mcb_defs.vh */
`ifndef MCB_DEFS_VH
`define MCB_DEFS_VH

// register byte offsets
`define MCB_OFS_CAP_POINTER   12'h034
`define MCB_OFS_CONTROL       12'h080
`define MCB_OFS_ADDR_LOW      12'h084
`define MCB_OFS_ADDR_HIGH     12'h088
`define MCB_OFS_PAYLOAD       12'h08C
`define MCB_OFS_IRQ_STATUS    12'h0C0
`define MCB_OFS_IRQ_MASK      12'h0C4
`define MCB_OFS_EXT_CAP       12'h100

// control register field positions
`define MCB_MASKING_BIT       24
`define MCB_WIDE_BIT          23
`define MCB_ALLOC_HI          22
`define MCB_ALLOC_LO          20
`define MCB_REQ_HI            19
`define MCB_REQ_LO            17
`define MCB_ENABLE_BIT        16
`define MCB_NEXT_HI           15
`define MCB_NEXT_LO           8
`define MCB_CAPID_HI          7
`define MCB_CAPID_LO          0

// fixed and reset field values
`define MCB_MASKING_VALUE     1'b1
`define MCB_WIDE_VALUE        1'b1
`define MCB_REQ_VALUE         3'h3
`define MCB_NEXT_VALUE        8'hA0
`define MCB_CAPID_VALUE       8'h05
`define MCB_CONTROL_RESET     32'h0186_A005
`define MCB_ALLOC_RESET       3'h0
`define MCB_ENABLE_RESET      1'b0
`define MCB_ALLOC_MAX         3'h3

// number of interrupt sources, one per vector
`define MCB_VECTORS           8

// ahb encodings
`define MCB_HTRANS_NONSEQ     2'h2
`define MCB_HTRANS_SEQ        2'h3
`define MCB_HRESP_OKAY        1'b0

`endif

/* hdl/mcb_msg_writer.v */
`timescale 1ns/1ps
`default_nettype none
`include "mcb_defs.vh"

module mcb_msg_writer (
    // clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // pending vectors and configuration
    input  wire [7:0]  pending,
    input  wire        enable,
    input  wire [2:0]  alloc,
    input  wire [29:0] addr_low,
    input  wire [31:0] addr_high,
    input  wire [15:0] payload,
    // one-cycle grant of the vector taken
    output reg  [7:0]  grant,
    // upstream posted write
    output reg         msg_valid,
    output reg  [63:0] msg_addr,
    output reg         msg_wide,
    output reg  [15:0] msg_data,
    input  wire        msg_ready
);

    reg [2:0] vec;
    reg       any;
    integer   i;

    // lowest pending vector wins; fixed priority keeps it simple
    always @* begin
        vec = 3'h0;
        any = 1'b0;
        for (i = `MCB_VECTORS - 1; i >= 0; i = i - 1) begin
            if (pending[i]) begin
                vec = i[2:0];
                any = 1'b1;
            end
        end
    end

    // merge vector into low data bits, only as many as allocated
    function [15:0] mcb_vector_data;
        input [15:0] base;
        input [2:0]  count;
        input [2:0]  v;
        reg   [2:0]  n;
        reg   [15:0] keep;
        begin
            n = (count > `MCB_ALLOC_MAX) ? `MCB_ALLOC_MAX : count;
            keep = 16'hFFFF << n;
            mcb_vector_data = (base & keep) | ({13'h0000, v} & ~keep);
        end
    endfunction

    // one message in flight, held until the upstream side takes it
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            grant     <= 8'h00;
            msg_valid <= 1'b0;
            msg_addr  <= 64'h0000_0000_0000_0000;
            msg_wide  <= 1'b0;
            msg_data  <= 16'h0000;
        end else begin
            grant <= 8'h00;
            if (msg_valid) begin
                if (msg_ready)
                    msg_valid <= 1'b0;
            end else if (enable && any) begin
                msg_valid <= 1'b1;
                grant     <= 8'h01 << vec;
                msg_addr  <= {addr_high, addr_low, 2'b00};
                msg_wide  <= (addr_high != 32'h0000_0000);
                msg_data  <= mcb_vector_data(payload, alloc, vec);
            end
        end
    end

endmodule

`default_nettype wire
